// >>> rtl/otf_framer.v
// Overview of operation
// - Only one 64 kbps channel is carried, one payload byte per frame.
// - Each frame is 256 bits sent 8000 times a second, 2048 kbps on line.
// - Timeslot 0 carries the alternating alignment words so a mux locks.
// - Internal timing makes the transmit bit clock from the core clock.
// - Loop timing takes the transmit bit clock from the received line.
// - Only one end of a link may be the timing source.
// - Switch 0 of the six static switches selects the clock configuration; the other five are unused.
`timescale 1ns/1ns
`default_nettype none
`include "otf_regs.vh"

module otf_framer
(
	// Clock and reset
	input wire CORE_CLK,
	input wire ARST_N,
	// Static configuration switches
	input wire [5:0] SW_CFG,
	// Line receive side
	input wire LINE_RX_CLK,
	input wire LINE_RXD,
	// Line transmit side
	output reg LINE_TX_CLK,
	output reg LINE_TXD,
	// Transmit payload
	input wire [7:0] TX_PAYLOAD,
	output reg TX_PAYLOAD_TAKE,
	// Receive payload and status
	output wire [7:0] RX_PAYLOAD,
	output wire RX_PAYLOAD_VALID,
	output wire RX_LOF,
	output reg INTERNAL_TIMING
);

	// Synchronisers for switches and line pins
	reg [5:0] sw_meta_q;
	reg [5:0] sw_q;
	reg rxc_meta_q;
	reg rxc_q;
	reg rxc_prev_q;
	reg rxd_meta_q;
	reg rxd_q;
	// Bit-rate accumulator for internal timing
	reg [`OTF_ACC_W-1:0] acc_q;
	reg [`OTF_ACC_W-1:0] acc_d;
	reg nco_tick;
	// Transmit framing
	reg [2:0] bit_q;
	reg [4:0] slot_q;
	reg odd_q;
	reg [7:0] tx_sr_q;
	reg [2:0] bit_d;
	reg [4:0] slot_d;
	reg odd_d;
	reg [7:0] tx_sr_d;
	reg txd_d;
	reg take_d;
	reg [7:0] next_word;
	wire rx_rise;
	wire rx_fall;
	wire tx_tick;
	wire last_bit;
	wire [4:0] next_slot;
	wire lof;

	// Switch and line receive inputs pass two flip-flops before use
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			sw_meta_q <= 6'h00;
			sw_q <= 6'h00;
			rxc_meta_q <= 1'b0;
			rxc_q <= 1'b0;
			rxc_prev_q <= 1'b0;
			rxd_meta_q <= 1'b0;
			rxd_q <= 1'b0;
		end
		else
		begin
			sw_meta_q <= SW_CFG;
			sw_q <= sw_meta_q;
			rxc_meta_q <= LINE_RX_CLK;
			rxc_q <= rxc_meta_q;
			rxc_prev_q <= rxc_q;
			rxd_meta_q <= LINE_RXD;
			rxd_q <= rxd_meta_q;
		end
	end

	// Edges of the recovered line clock
	assign rx_rise = rxc_q & ~rxc_prev_q;
	assign rx_fall = ~rxc_q & rxc_prev_q;

	// Timing mode from the switches
	// switch decode
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			INTERNAL_TIMING <= 1'b0;
		else
			INTERNAL_TIMING <= sw_q[`OTF_SW_INTERNAL];
	end

	// Fractional divider: 2048 ticks per 10000 core cycles
	// internal bit clock
	always @*
	begin
		nco_tick = 1'b0;
		acc_d = acc_q + `OTF_ACC_INC;
		if (acc_d >= `OTF_ACC_MOD)
		begin
			acc_d = acc_d - `OTF_ACC_MOD;
			nco_tick = 1'b1;
		end
	end

	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			acc_q <= {`OTF_ACC_W{1'b0}};
		else
			acc_q <= acc_d;
	end

	// Transmit bit strobe from the selected source
	// loop timing source
	assign tx_tick = INTERNAL_TIMING ? nco_tick : rx_fall;

	// Transmit clock out: internal halves, or line clock echoed
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			LINE_TX_CLK <= 1'b0;
		else if (INTERNAL_TIMING)
			LINE_TX_CLK <= (acc_q >= `OTF_ACC_HALF);
		else
			LINE_TX_CLK <= rxc_q;
	end

	// Frame position: 8 bits per slot, 32 slots per frame
	assign last_bit = (bit_q == 3'h7);
	assign next_slot = slot_q + 5'h01;

	// Word for the next timeslot
	// alignment words
	always @*
	begin
		next_word = `OTF_IDLE_WORD;
		if (next_slot == `OTF_SLOT_ALIGN)
		begin
			if (odd_q)
				next_word = `OTF_FAS_WORD;
			else if (lof)
				next_word = `OTF_NFAS_RAI;
			else
				next_word = `OTF_NFAS_WORD;
		end
		else if (next_slot == `OTF_SLOT_PAYLOAD)
			next_word = TX_PAYLOAD;
	end

	// Next bit, slot and frame position on each transmit strobe
	// 256-bit frame
	always @*
	begin
		bit_d = bit_q;
		slot_d = slot_q;
		odd_d = odd_q;
		tx_sr_d = tx_sr_q;
		txd_d = LINE_TXD;
		take_d = 1'b0;
		if (tx_tick)
		begin
			bit_d = bit_q + 3'h1;
			if (last_bit)
			begin
				// New slot: its word goes out MSB first
				slot_d = next_slot;
				if (next_slot == `OTF_SLOT_ALIGN)
					odd_d = ~odd_q;
				txd_d = next_word[7];
				tx_sr_d = {next_word[6:0], 1'b1};
				take_d = (next_slot == `OTF_SLOT_PAYLOAD);
			end
			else
			begin
				txd_d = tx_sr_q[7];
				tx_sr_d = {tx_sr_q[6:0], 1'b1};
			end
		end
	end

	// Transmit shift register and frame counters
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			bit_q <= 3'h7; // First strobe opens slot 0
			slot_q <= 5'h1f;
			odd_q <= 1'b1; // First frame carries the alignment word
			tx_sr_q <= `OTF_IDLE_WORD;
			LINE_TXD <= 1'b1;
			TX_PAYLOAD_TAKE <= 1'b0;
		end
		else
		begin
			bit_q <= bit_d;
			slot_q <= slot_d;
			odd_q <= odd_d;
			tx_sr_q <= tx_sr_d;
			LINE_TXD <= txd_d;
			TX_PAYLOAD_TAKE <= take_d;
		end
	end

	// Receive alignment and payload extraction
	// frame search
	otf_frame_sync u_sync
	(
		.clk(CORE_CLK),
		.arst_n(ARST_N),
		.bit_stb(rx_rise),
		.bit_in(rxd_q),
		.lof(lof),
		.pay_data(RX_PAYLOAD),
		.pay_stb(RX_PAYLOAD_VALID)
	);

	assign RX_LOF = lof;

endmodule
`default_nettype wire

// >>> common/otf_regs.vh
`ifndef OTF_REGS_VH
`define OTF_REGS_VH

// Frame geometry: one 256-bit frame, 8000 frames per second
`define OTF_FRAME_BITS 256
`define OTF_FRAME_HZ 8000
`define OTF_BYTE_BITS 8

// Line rate and core rate in kHz, for the bit-rate accumulator
`define OTF_LINE_KHZ 2048
`define OTF_CORE_KHZ 10000
`define OTF_ACC_W 14
`define OTF_ACC_INC 14'h0800
`define OTF_ACC_MOD 14'h2710
`define OTF_ACC_HALF 14'h1388

// Timeslot 0 words: alignment word on even frames, other word on odd
`define OTF_FAS_WORD 8'h9b
`define OTF_NFAS_WORD 8'hdf
`define OTF_NFAS_RAI 8'hff
`define OTF_IDLE_WORD 8'hff
`define OTF_FAS_PAT 7'h1b

// Timeslot positions in the 32-slot frame
`define OTF_SLOT_ALIGN 5'h00
`define OTF_SLOT_PAYLOAD 5'h01

// Receiver bit positions counted from the end of an alignment word
`define OTF_RX_POS_PAY0 9'h007
`define OTF_RX_POS_NFAS 9'h0ff
`define OTF_RX_POS_PAY1 9'h107
`define OTF_RX_POS_FAS 9'h1ff

// Consecutive word errors that drop frame alignment
`define OTF_LOF_ERRS 2'h3

// Switch fields
`define OTF_SW_INTERNAL 0

`endif

// >>> rtl/otf_frame_sync.v
`timescale 1ns/1ns
`default_nettype none
`include "otf_regs.vh"

module otf_frame_sync
(
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Received bit stream
	input wire bit_stb,
	input wire bit_in,
	// Alignment and payload
	output reg lof,
	output reg [7:0] pay_data,
	output reg pay_stb
);

	localparam ST_HUNT = 2'h0;
	localparam ST_CONFIRM = 2'h1;
	localparam ST_SYNC = 2'h2;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [7:0] sr_q;
	reg [7:0] sr_d;
	reg [8:0] pos_q;
	reg [8:0] pos_d;
	reg [1:0] errs_q;
	reg [1:0] errs_d;
	wire [7:0] sr_n;
	wire fas_ok;
	wire nfas_ok;
	wire at_fas;
	wire at_nfas;
	wire at_check;
	wire word_ok;
	wire at_pay;
	wire pay_hit;
	wire last_err;

	// Shift register holding the last eight bits, first bit in bit 7
	assign sr_n = {sr_q[6:0], bit_in};
	assign fas_ok = (sr_n[6:0] == `OTF_FAS_PAT);
	assign nfas_ok = sr_n[6];
	assign at_fas = (pos_q == `OTF_RX_POS_FAS);
	assign at_nfas = (pos_q == `OTF_RX_POS_NFAS);
	assign at_check = at_fas | at_nfas;
	assign word_ok = at_fas ? fas_ok : nfas_ok;
	assign at_pay = (pos_q == `OTF_RX_POS_PAY0) |
		(pos_q == `OTF_RX_POS_PAY1);

	// Payload byte complete while aligned; last tolerated word error
	assign pay_hit = bit_stb && at_pay && (state_q == ST_SYNC);
	assign last_err = (errs_q == (`OTF_LOF_ERRS - 2'h1));

	// Alignment search and check, one step per received bit
	// hunt and check
	always @*
	begin
		state_d = state_q;
		sr_d = sr_q;
		pos_d = pos_q;
		errs_d = errs_q;
		if (bit_stb)
		begin
			sr_d = sr_n;
			pos_d = pos_q + 9'h001;
			case (state_q)
				ST_HUNT:
				begin
					pos_d = 9'h000;
					if (fas_ok)
						state_d = ST_CONFIRM;
				end
				ST_CONFIRM:
				begin
					if (at_check && !word_ok)
						state_d = ST_HUNT;
					else if (at_fas)
					begin
						state_d = ST_SYNC;
						errs_d = 2'h0;
					end
				end
				ST_SYNC:
				begin
					if (at_check && word_ok)
						errs_d = 2'h0;
					else if (at_check)
					begin
						errs_d = errs_q + 2'h1;
						if (last_err)
							state_d = ST_HUNT;
					end
				end
				default:
					state_d = ST_HUNT;
			endcase
		end
	end

	// State registers, held between received bits by the next-state logic
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= ST_HUNT;
			sr_q <= 8'h00;
			pos_q <= 9'h000;
			errs_q <= 2'h0;
		end
		else
		begin
			state_q <= state_d;
			sr_q <= sr_d;
			pos_q <= pos_d;
			errs_q <= errs_d;
		end
	end

	// Outputs: loss flag and payload byte
	// loss report
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lof <= 1'b1;
			pay_data <= 8'h00;
			pay_stb <= 1'b0;
		end
		else
		begin
			lof <= (state_q != ST_SYNC);
			pay_stb <= pay_hit;
			pay_data <= pay_hit ? sr_n : pay_data;
		end
	end

endmodule
`default_nettype wire

// >>> rtl/otf_dummy_unused.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> dv/otf_framer_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module otf_framer_monitor
(
	// Clock and reset
	input wire CORE_CLK,
	input wire ARST_N,
	// Switches and line
	input wire [5:0] SW_CFG,
	input wire LINE_RX_CLK,
	input wire LINE_TX_CLK,
	input wire LINE_TXD,
	// Payload and status
	input wire TX_PAYLOAD_TAKE,
	input wire [7:0] RX_PAYLOAD,
	input wire RX_PAYLOAD_VALID,
	input wire RX_LOF,
	input wire INTERNAL_TIMING
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	logic [2:0] age_q;
	wire ok;
	assign ok = age_q == 3'h7;
	// Cycles since reset release
	always @(posedge CORE_CLK or negedge ARST_N)
		if (!ARST_N)
			age_q <= 3'h0;
		else if (!ok)
			age_q <= age_q + 3'h1;
	AST_TAKE_ONCE: assert property (
		TX_PAYLOAD_TAKE |=> !TX_PAYLOAD_TAKE [*8]) else $error("take twice");
	AST_VALID_ONCE: assert property (
		RX_PAYLOAD_VALID |=> !RX_PAYLOAD_VALID [*8]) else $error("valid twice");
	AST_NO_PAY_LOF: assert property (
		RX_PAYLOAD_VALID |-> !RX_LOF) else $error("payload while lost");
	AST_PAY_HOLD: assert property (
		!RX_PAYLOAD_VALID |-> $stable(RX_PAYLOAD)) else $error("payload moved");
	AST_BIT_HOLD: assert property (
		ok && $changed(LINE_TXD) |=> $stable(LINE_TXD) [*3])
		else $error("bit too short");
	AST_MODE: assert property (
		(ok && $stable(SW_CFG[0])) [*4] |-> INTERNAL_TIMING == SW_CFG[0])
		else $error("mode not switch");
	AST_INT_CLK: assert property (
		ok && INTERNAL_TIMING && $rose(LINE_TX_CLK) |-> ##[1:4] $fell(LINE_TX_CLK))
		else $error("internal clock stuck");
	AST_LOOP_CLK: assert property (
		ok && !INTERNAL_TIMING && $rose(LINE_RX_CLK) |-> ##[2:5] $rose(LINE_TX_CLK))
		else $error("loop clock lost");
	COV_ALIGN: cover property ($fell(RX_LOF));
	COV_PAY: cover property (RX_PAYLOAD_VALID);
	COV_LOOP: cover property (!INTERNAL_TIMING && TX_PAYLOAD_TAKE);
endmodule
bind otf_framer otf_framer_monitor mon (.*);
`default_nettype wire

// >>> dv/otf_mux_model.sv
`timescale 1ns/1ns
`default_nettype none
module otf_mux_model
(
	// Control
	input wire logic en,
	input wire logic bad,
	input wire logic [7:0] pay,
	// Line toward the framer
	output logic line_clk,
	output logic line_d
);
	logic odd;
	logic [7:0] w;
	int n;
	initial
	begin
		line_clk = 1'b0;
		line_d = 1'b1;
		odd = 1'b0;
		#37;
		forever
			if (!en)
			begin
				// Clock still, data wanders
				line_d = ~line_d;
				#400;
			end
			else
			begin
				for (n = 0; n < 256; n++)
				begin
					w = n < 8 ? (odd ? 8'hdf : 8'h9b) ^ {1'b0, {7{bad}}} :
						n < 16 ? pay : 8'hff;
					line_d = w[7 - n % 8];
					#400 line_clk = 1'b1;
					#400 line_clk = 1'b0;
				end
				odd = ~odd;
			end
	end
endmodule
`default_nettype wire

// >>> dv/otf_framer_test.sv
`timescale 1ns/1ns
`default_nettype none
module otf_framer_test;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [5:0] sw_cfg = 6'h01;
	logic [7:0] tx_pay = 8'ha5;
	logic en = 1'b0;
	logic bad = 1'b0;
	wire rx_clk, rxd, tx_clk, txd, take, rx_valid, lof, int_tm;
	wire [7:0] rx_pay;
	int num_errors = 0;
	int checks_done = 0;
	int span;
	logic [7:0] w1, w2;
	// Clock
	always #50 core_clk = ~core_clk;
	otf_framer uut (.CORE_CLK(core_clk), .ARST_N(arst_n), .SW_CFG(sw_cfg),
		.LINE_RX_CLK(rx_clk), .LINE_RXD(rxd), .LINE_TX_CLK(tx_clk),
		.LINE_TXD(txd), .TX_PAYLOAD(tx_pay), .TX_PAYLOAD_TAKE(take),
		.RX_PAYLOAD(rx_pay), .RX_PAYLOAD_VALID(rx_valid), .RX_LOF(lof),
		.INTERNAL_TIMING(int_tm));
	otf_mux_model mux (.en(en), .bad(bad), .pay(8'h5a), .line_clk(rx_clk),
		.line_d(rxd));
	task automatic chk(input string nm, input logic [15:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Bounded wait: 0 take, 1 lof, 2 valid
	task automatic wait_for(input int s, input logic v, input int lim);
		int n;
		n = 0;
		while ((s == 0 ? take : s == 1 ? lof : rx_valid) !== v)
		begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > lim)
			begin
				chk("wait", {15'h0, v}, {15'h0, ~v});
				conclude();
			end
		end
	endtask
	// Take to take, grabbing the next slot 0 word
	task automatic frame(output logic [7:0] w, input int num, input int den);
		int c;
		c = 0;
		w = 8'h00;
		do
		begin
			@(posedge core_clk);
			#1;
			c++;
			for (int j = 0; j < 8; j++)
				if (c == ((248 + j) * num) / den + 2)
					w[7 - j] = txd;
		end
		while (take !== 1'b1 && c < 2200);
		span = c;
		if (take !== 1'b1)
		begin
			chk("frame wait", 16'h0001, {15'h0, take});
			conclude();
		end
	endtask
	task automatic t_reset();
		repeat (10) @(posedge core_clk);
		#1;
		chk("reset outs", 16'h000c, {rx_pay, 2'h0, tx_clk,
			rx_valid, txd, lof, take, int_tm});
		$display("reset done");
		arst_n = 1'b1;
	endtask
	task automatic t_internal();
		repeat (4) @(posedge core_clk);
		#1;
		chk("internal mode", 16'h0001, {15'h0, int_tm});
		wait_for(0, 1'b1, 1400);
		chk("payload bit a", 16'h0001, {15'h0, txd});
		tx_pay = 8'h3c;
		frame(w1, 10000, 2048);
		chk("frame span", 16'h04e2, span[15:0]);
		chk("payload bit b", 16'h0000, {15'h0, txd});
		frame(w2, 10000, 2048);
		chk("word pair", 16'h0064, {8'h00, w1 ^ w2});
		chk("align word", 16'h009b, {8'h00, w1 & w2});
		$display("internal timing done");
	endtask
	task automatic t_loop();
		arst_n = 1'b0;
		sw_cfg = 6'h00;
		repeat (10) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		en = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk("loop mode", 16'h0000, {15'h0, int_tm});
		wait_for(1, 1'b0, 12000);
		wait_for(2, 1'b1, 2100);
		chk("rx payload", 16'h005a, {8'h00, rx_pay});
		wait_for(0, 1'b1, 2100);
		frame(w1, 8, 1);
		chk("loop span", 16'h0800, span[15:0]);
		frame(w2, 8, 1);
		chk("loop word pair", 16'h0044, {8'h00, w1 ^ w2});
		chk("loop align word", 16'h009b, {8'h00, w1 & w2});
		bad = 1'b1;
		wait_for(1, 1'b1, 10000);
		bad = 1'b0;
		$display("loop timing done");
	endtask
	// Main sequence
	initial
	begin
		t_reset();
		t_internal();
		t_loop();
		conclude();
	end
endmodule
`default_nettype wire
